// ===== rtl/easy_config_pin_mux.sv
// preset pin configuration registers and pin function decode
`timescale 1ns/1ps
`default_nettype none

module easy_config_pin_mux
	import pin_mux_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	// register port
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	// monitoring gate
	output logic            monitor_en_o,
	// pin functions
	output logic      [7:0] fan_speed_in_en_o,
	output logic      [3:0] fan_drive_out_en_o,
	output logic      [1:0] remote_diode_en_o,
	output logic      [1:0] termination_sense_en_o,
	output logic      [1:0] core_voltage_en_o,
	output logic      [1:0] regulator_overheat_en_o,
	output logic      [2:0] v12_en_o,
	output logic            v5_en_o,
	output logic            v3v3_en_o,
	output logic            v2v5_en_o,
	output logic            v1v8_en_o,
	output logic            v1v2_en_o,
	output logic            v0v9_en_o,
	output logic            battery_voltage_en_o,
	output logic      [1:0] v1v5_gpio_en_o,
	output logic      [1:0] thermal_io_en_o,
	output logic            chassis_intrusion_en_o,
	output logic            fan_full_speed_in_en_o,
	output logic            voltage_id_inputs_en_o
);
	import pin_mux_pkg::*;

	// ------------------------------------------
	// registers
	// ------------------------------------------
	logic [7:0]          gcfg1_ff;
	logic [7:0]          pfs1_ff;
	logic [7:0]          pfs2_ff;
	logic [7:0]          pfs3_ff;
	logic [7:0]          pfs4_ff;
	logic [OPT_BITS-1:0] preset_ff;
	logic [2:0]          opt_sel;
	logic                wr;

	assign wr = ce_i && reg_wr_i;

	// lowest set option bit wins
	always_comb begin
		opt_sel = 3'h0;
		for (int i = OPT_BITS - 1; i >= 0; i--) begin
			if (reg_wdata_i[i]) begin
				opt_sel = 3'(i + 1);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			gcfg1_ff <= GCFG1_RST;
		end else if (wr && reg_addr_i == ADDR_GCFG1) begin
			gcfg1_ff <= reg_wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			preset_ff <= PRESET_RST;
		end else if (wr && reg_addr_i == ADDR_PRESET) begin
			preset_ff <= reg_wdata_i[OPT_BITS-1:0];
		end
	end

	// preset load or single register override
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pfs1_ff <= OPT1_PFS1;
			pfs2_ff <= OPT1_PFS2;
			pfs3_ff <= OPT1_PFS3;
			pfs4_ff <= OPT1_PFS4;
		end else if (wr && reg_addr_i == ADDR_PRESET) begin
			case (opt_sel)
				3'h1: begin
					pfs1_ff <= OPT1_PFS1;
					pfs2_ff <= OPT1_PFS2;
					pfs3_ff <= OPT1_PFS3;
					pfs4_ff <= OPT1_PFS4;
				end
				3'h2: begin
					pfs1_ff <= OPT2_PFS1;
					pfs2_ff <= OPT2_PFS2;
					pfs3_ff <= OPT2_PFS3;
					pfs4_ff <= OPT2_PFS4;
				end
				3'h3: begin
					pfs1_ff <= OPT3_PFS1;
					pfs2_ff <= OPT3_PFS2;
					pfs3_ff <= OPT3_PFS3;
					pfs4_ff <= OPT3_PFS4;
				end
				// options 4 and 5 leave the pins as they are
				default: begin
					pfs1_ff <= pfs1_ff;
				end
			endcase
		end else if (wr) begin
			case (reg_addr_i)
				ADDR_PFS1: pfs1_ff <= reg_wdata_i;
				ADDR_PFS2: pfs2_ff <= reg_wdata_i;
				ADDR_PFS3: pfs3_ff <= reg_wdata_i;
				ADDR_PFS4: pfs4_ff <= reg_wdata_i;
				default:   pfs1_ff <= pfs1_ff;
			endcase
		end
	end

	// ------------------------------------------
	// read port, unmapped reads give zero
	// ------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (ce_i && reg_rd_i) begin
			case (reg_addr_i)
				ADDR_GCFG1:  reg_rdata_o <= gcfg1_ff;
				ADDR_PFS1:   reg_rdata_o <= pfs1_ff;
				ADDR_PFS2:   reg_rdata_o <= pfs2_ff;
				ADDR_PFS3:   reg_rdata_o <= pfs3_ff;
				ADDR_PFS4:   reg_rdata_o <= pfs4_ff;
				ADDR_PRESET: reg_rdata_o <= {3'h0, preset_ff};
				default:     reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------
	// pin function decode
	// ------------------------------------------
	logic       volt_id;
	logic [7:0] nxt_tach;
	logic [3:0] nxt_pwm;
	logic [1:0] nxt_therm;
	logic [1:0] nxt_gpio;

	assign volt_id = pfs1_ff[VOLT_ID_BIT];

	// tach 1..4 share pins with volt-id inputs
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_tach
			assign nxt_tach[g] = pfs1_ff[4-g] && !volt_id;
		end
	endgenerate

	assign nxt_tach[4] = pfs1_ff[0];
	assign nxt_tach[5] = pfs2_ff[7];
	assign nxt_tach[6] = pfs2_ff[3];
	assign nxt_tach[7] = pfs2_ff[2];
	assign nxt_pwm[0]  = pfs4_ff[3] && !volt_id;
	assign nxt_pwm[1]  = pfs4_ff[2] && !volt_id;
	assign nxt_pwm[2]  = 1'b1;
	assign nxt_pwm[3]  = pfs2_ff[6];
	assign nxt_therm[0] = pfs4_ff[7] && !volt_id;
	assign nxt_therm[1] = pfs4_ff[5];
	assign nxt_gpio[0] = pfs4_ff[7:6] == 2'b01 && !volt_id;
	assign nxt_gpio[1] = pfs4_ff[5:4] == 2'b01;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			fan_speed_in_en_o       <= 8'h00;
			fan_drive_out_en_o      <= 4'h0;
			thermal_io_en_o         <= 2'h0;
			v1v5_gpio_en_o          <= 2'h0;
			voltage_id_inputs_en_o  <= 1'b0;
			remote_diode_en_o       <= 2'h0;
			termination_sense_en_o  <= 2'h0;
			core_voltage_en_o       <= 2'h0;
			regulator_overheat_en_o <= 2'h0;
			v12_en_o                <= 3'h0;
			v5_en_o                 <= 1'b0;
			v3v3_en_o               <= 1'b0;
			v2v5_en_o               <= 1'b0;
			v1v8_en_o               <= 1'b0;
			v1v2_en_o               <= 1'b0;
			v0v9_en_o               <= 1'b0;
			battery_voltage_en_o    <= 1'b0;
			chassis_intrusion_en_o  <= 1'b0;
			fan_full_speed_in_en_o  <= 1'b0;
		end else if (ce_i) begin
			fan_speed_in_en_o      <= nxt_tach;
			fan_drive_out_en_o     <= nxt_pwm;
			thermal_io_en_o        <= nxt_therm;
			v1v5_gpio_en_o         <= nxt_gpio;
			voltage_id_inputs_en_o <= volt_id;
			remote_diode_en_o <= {pfs1_ff[5], pfs1_ff[6]};
			termination_sense_en_o <= ~{pfs1_ff[5], pfs1_ff[6]};
			v0v9_en_o <= !pfs1_ff[5];
			core_voltage_en_o[0] <= pfs2_ff[1:0] == 2'b00;
			core_voltage_en_o[1] <= pfs3_ff[7:6] == 2'b00;
			v1v8_en_o <= !pfs1_ff[6] || pfs2_ff[1:0] == 2'b10;
			v2v5_en_o <= pfs3_ff[7:6] == 2'b01;
			regulator_overheat_en_o[0] <= pfs3_ff[5];
			regulator_overheat_en_o[1] <= pfs3_ff[3];
			v3v3_en_o <= !pfs2_ff[6] || pfs3_ff[5:4] == 2'b00;
			v1v2_en_o <= pfs3_ff[5:4] == 2'b01;
			battery_voltage_en_o <= pfs3_ff[3:2] == 2'b00;
			v12_en_o <= {!pfs2_ff[2], !pfs2_ff[7], !pfs1_ff[0]};
			v5_en_o  <= !pfs2_ff[3];
			chassis_intrusion_en_o <= pfs3_ff[1];
			fan_full_speed_in_en_o <= !pfs3_ff[1];
		end
	end

	// monitoring starts only once setup is declared done
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			monitor_en_o <= 1'b0;
		end else if (ce_i) begin
			monitor_en_o <= gcfg1_ff[SETUP_DONE_BIT];
		end
	end

	// ------------------------------------------
	// checks
	// ------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	chk_reset_default: assert property (
		!$past(rst_n_i) |-> pfs1_ff == OPT1_PFS1 &&
		pfs2_ff == OPT1_PFS2 && pfs3_ff == OPT1_PFS3 &&
		pfs4_ff == OPT1_PFS4)
		else $error("reset pattern is not option 1");

	chk_opt1_load: assert property (
		wr && reg_addr_i == ADDR_PRESET && reg_wdata_i[0]
		|=> pfs2_ff == OPT1_PFS2 && pfs3_ff == OPT1_PFS3)
		else $error("option 1 preset not loaded");

	chk_lowest_wins: assert property (
		wr && reg_addr_i == ADDR_PRESET && reg_wdata_i[1:0] == 2'b10
		|=> pfs3_ff == OPT2_PFS3 && pfs2_ff == OPT2_PFS2)
		else $error("option 2 preset not loaded");

	chk_opt3_load: assert property (
		wr && reg_addr_i == ADDR_PRESET && reg_wdata_i[2:0] == 3'b100
		|=> pfs1_ff == OPT3_PFS1 && pfs4_ff == OPT3_PFS4)
		else $error("option 3 preset not loaded");

	chk_pin_override: assert property (
		wr && reg_addr_i == ADDR_PFS3 |=> pfs3_ff == $past(reg_wdata_i))
		else $error("pin write did not override");

	chk_monitor_gate: assert property (
		ce_i && !gcfg1_ff[SETUP_DONE_BIT] |=> !monitor_en_o)
		else $error("monitoring before setup done");

	chk_monitor_follow: assert property (
		ce_i && gcfg1_ff[SETUP_DONE_BIT] |=> monitor_en_o)
		else $error("monitoring did not start");

	chk_voltid_override: assert property (
		voltage_id_inputs_en_o |-> fan_speed_in_en_o[3:0] == 4'h0 &&
		fan_drive_out_en_o[1:0] == 2'h0 && !thermal_io_en_o[0] &&
		!v1v5_gpio_en_o[0])
		else $error("volt-id pin still has other function");

	chk_tach_select: assert property (
		ce_i && !volt_id |=>
		fan_speed_in_en_o[3:0] == {$past(pfs1_ff[1]), $past(pfs1_ff[2]),
		$past(pfs1_ff[3]), $past(pfs1_ff[4])})
		else $error("tach 1 to 4 decode wrong");

	chk_fan_speed_in_6_mux: assert property (
		ce_i |=> fan_speed_in_en_o[5] == $past(pfs2_ff[7]) &&
		v12_en_o[1] != $past(pfs2_ff[7]))
		else $error("tach 6 pin decode wrong");

	chk_diode1_pair: assert property (
		ce_i |=> remote_diode_en_o[0] == $past(pfs1_ff[6]) &&
		termination_sense_en_o[0] != $past(pfs1_ff[6]))
		else $error("diode 1 pair decode wrong");

	chk_diode3_pair: assert property (
		ce_i && !pfs1_ff[5] |=> !remote_diode_en_o[1] &&
		termination_sense_en_o[1] && v0v9_en_o)
		else $error("diode 3 pair decode wrong");

	chk_tach78_mux: assert property (
		ce_i && pfs2_ff[3:2] == 2'b00 |=>
		fan_speed_in_en_o[7:6] == 2'h0 && v5_en_o && v12_en_o[2])
		else $error("tach 7 and 8 pin decode wrong");

	chk_core1_sel: assert property (
		ce_i && pfs2_ff[1:0] == 2'b00 |=> core_voltage_en_o[0])
		else $error("core voltage 1 not selected");

	chk_v1v8_sel: assert property (
		ce_i && pfs2_ff[1:0] == 2'b10 |=> v1v8_en_o &&
		!core_voltage_en_o[0])
		else $error("1.8 V input not selected");

	chk_core2_sel: assert property (
		ce_i |=>
		core_voltage_en_o[1] == ($past(pfs3_ff[7:6]) == 2'b00) &&
		v2v5_en_o == ($past(pfs3_ff[7:6]) == 2'b01))
		else $error("core voltage 2 pin decode wrong");

	chk_overheat1_sel: assert property (
		ce_i && pfs3_ff[5] |=> regulator_overheat_en_o[0] && !v1v2_en_o)
		else $error("regulator overheat 1 not selected");

	chk_v1v2_sel: assert property (
		ce_i && pfs3_ff[5:4] == 2'b01 |=> v1v2_en_o)
		else $error("1.2 V input not selected");

	chk_overheat2_sel: assert property (
		ce_i && pfs3_ff[3] |=> regulator_overheat_en_o[1] &&
		!battery_voltage_en_o)
		else $error("regulator overheat 2 not selected");

	chk_intrusion_sel: assert property (
		ce_i |=> chassis_intrusion_en_o == $past(pfs3_ff[1]) &&
		fan_full_speed_in_en_o != $past(pfs3_ff[1]))
		else $error("intrusion pin decode wrong");

	chk_thermal1_sel: assert property (
		ce_i && !volt_id && pfs4_ff[7] |=> thermal_io_en_o[0] &&
		!v1v5_gpio_en_o[0])
		else $error("thermal 1 pin decode wrong");

	chk_thermal2_sel: assert property (
		ce_i && pfs4_ff[5:4] == 2'b01 |=> v1v5_gpio_en_o[1] &&
		!thermal_io_en_o[1])
		else $error("thermal 2 pin decode wrong");

	chk_pwm12_en: assert property (
		ce_i && !volt_id |=> fan_drive_out_en_o[1:0] ==
		{$past(pfs4_ff[2]), $past(pfs4_ff[3])})
		else $error("pwm 1 and 2 enable wrong");

	chk_fan_speed_in_5_mux: assert property (
		ce_i && pfs1_ff[0] |=> fan_speed_in_en_o[4] && !v12_en_o[0])
		else $error("tach 5 pin decode wrong");

	chk_fan_drive_out_4_mux: assert property (
		ce_i && !pfs2_ff[6] |=> !fan_drive_out_en_o[3] && v3v3_en_o)
		else $error("pwm 4 pin decode wrong");

	chk_ce_freeze: assert property (
		!ce_i |=> $stable(pfs1_ff) && $stable(gcfg1_ff) &&
		$stable(monitor_en_o) && $stable(reg_rdata_o))
		else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ===== rtl/pin_mux_pkg.sv
// constants for the preset pin multiplexer
package pin_mux_pkg;

	// ------------------------------------------
	// register offsets
	// ------------------------------------------
	localparam logic [7:0] ADDR_GCFG1  = 8'h01;
	localparam logic [7:0] ADDR_PFS1   = 8'h10;
	localparam logic [7:0] ADDR_PFS2   = 8'h11;
	localparam logic [7:0] ADDR_PFS3   = 8'h12;
	localparam logic [7:0] ADDR_PFS4   = 8'h13;
	localparam logic [7:0] ADDR_PRESET = 8'h14;

	// ------------------------------------------
	// field positions
	// ------------------------------------------
	localparam int SETUP_DONE_BIT = 5;
	localparam int VOLT_ID_BIT    = 7;
	localparam int OPT_BITS       = 5;

	// ------------------------------------------
	// values after reset
	// ------------------------------------------
	localparam logic [7:0] GCFG1_RST  = 8'h00;
	localparam logic [4:0] PRESET_RST = 5'h01;

	// ------------------------------------------
	// preset patterns, option 1 is the reset value
	// ------------------------------------------
	localparam logic [7:0] OPT1_PFS1 = 8'h7F;
	localparam logic [7:0] OPT1_PFS2 = 8'hCE;
	localparam logic [7:0] OPT1_PFS3 = 8'h42;
	localparam logic [7:0] OPT1_PFS4 = 8'hAC;
	localparam logic [7:0] OPT2_PFS1 = 8'h7F;
	localparam logic [7:0] OPT2_PFS2 = 8'hCC;
	localparam logic [7:0] OPT2_PFS3 = 8'h28;
	localparam logic [7:0] OPT2_PFS4 = 8'hAC;
	localparam logic [7:0] OPT3_PFS1 = 8'h1E;
	localparam logic [7:0] OPT3_PFS2 = 8'h00;
	localparam logic [7:0] OPT3_PFS3 = 8'h12;
	localparam logic [7:0] OPT3_PFS4 = 8'h5C;

endpackage

// ===== tb/tb_easy_config_pin_mux.sv
// self-checking bench for the preset pin multiplexer
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
	end \
end

module tb_easy_config_pin_mux;
	import pin_mux_pkg::*;

	// ------------------------------------------
	// signals
	// ------------------------------------------
	logic        mclk;
	logic        rst_n;
	logic        ce;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  rdata;
	logic        mon;
	logic [7:0]  fs;
	logic [3:0]  fd;
	logic [1:0]  rdi;
	logic [1:0]  ts;
	logic [1:0]  cv;
	logic [1:0]  ro;
	logic [2:0]  v12;
	logic        v5;
	logic        v3v3;
	logic        v2v5;
	logic        v1v8;
	logic        v1v2;
	logic        v0v9;
	logic        batt;
	logic [1:0]  gp;
	logic [1:0]  th;
	logic        intr;
	logic        ffs;
	logic        volt_id;
	logic [36:0] dec;
	int          fail_count;
	int          n_tests;

	assign dec = {fs, fd, rdi, ts, cv, ro, v12,
		v5, v3v3, v2v5, v1v8, v1v2, v0v9, batt, gp, th, intr, ffs, volt_id};

	// expected decode per preset
	localparam logic [36:0] D1 = {8'hFF, 4'hF, 2'b11, 2'b00, 2'b00,
		2'b00, 3'b000, 7'b0111001, 2'b00, 2'b11, 3'b100};
	localparam logic [36:0] D2 = {8'hFF, 4'hF, 2'b11, 2'b00, 2'b11,
		2'b11, 3'b000, 7'b0000000, 2'b00, 2'b11, 3'b010};
	localparam logic [36:0] D3 = {8'h0F, 4'h7, 2'b00, 2'b11, 2'b11,
		2'b00, 3'b111, 7'b1101111, 2'b11, 2'b00, 3'b100};

	easy_config_pin_mux dut (
		.mclk_i                  (mclk),
		.rst_n_i                 (rst_n),
		.ce_i                    (ce),
		.reg_wr_i                (reg_wr),
		.reg_rd_i                (reg_rd),
		.reg_addr_i              (reg_addr),
		.reg_wdata_i             (reg_wdata),
		.reg_rdata_o             (rdata),
		.monitor_en_o            (mon),
		.fan_speed_in_en_o       (fs),
		.fan_drive_out_en_o      (fd),
		.remote_diode_en_o       (rdi),
		.termination_sense_en_o  (ts),
		.core_voltage_en_o       (cv),
		.regulator_overheat_en_o (ro),
		.v12_en_o                (v12),
		.v5_en_o                 (v5),
		.v3v3_en_o               (v3v3),
		.v2v5_en_o               (v2v5),
		.v1v8_en_o               (v1v8),
		.v1v2_en_o               (v1v2),
		.v0v9_en_o               (v0v9),
		.battery_voltage_en_o    (batt),
		.v1v5_gpio_en_o          (gp),
		.thermal_io_en_o         (th),
		.chassis_intrusion_en_o  (intr),
		.fan_full_speed_in_en_o  (ffs),
		.voltage_id_inputs_en_o  (volt_id)
	);

	// ------------------------------------------
	// register port tasks
	// ------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		`CHK(rdata, e)
		@(negedge mclk);
	endtask

	task automatic regs4(input logic [7:0] e1, e2, e3, e4);
		rd_chk(ADDR_PFS1, e1);
		rd_chk(ADDR_PFS2, e2);
		rd_chk(ADDR_PFS3, e3);
		rd_chk(ADDR_PFS4, e4);
	endtask

	// preset write, then one edge for the decode to follow
	task automatic preset(input logic [7:0] d);
		wr(ADDR_PRESET, d);
		@(negedge mclk);
	endtask

	// ------------------------------------------
	// scenarios
	// ------------------------------------------
	task automatic t_reset;
		regs4(OPT1_PFS1, OPT1_PFS2, OPT1_PFS3, OPT1_PFS4);
		rd_chk(ADDR_PRESET, {3'h0, PRESET_RST});
		`CHK(dec, D1)
	endtask

	task automatic t_presets;
		preset(8'h04);
		regs4(OPT3_PFS1, OPT3_PFS2, OPT3_PFS3, OPT3_PFS4);
		`CHK(dec, D3)
		preset(8'h06);
		regs4(OPT2_PFS1, OPT2_PFS2, OPT2_PFS3, OPT2_PFS4);
		`CHK(dec, D2)
		preset(8'h08);
		regs4(OPT2_PFS1, OPT2_PFS2, OPT2_PFS3, OPT2_PFS4);
		rd_chk(ADDR_PRESET, 8'h08);
		preset(8'hE1);
		rd_chk(ADDR_PRESET, 8'h01);
		regs4(OPT1_PFS1, OPT1_PFS2, OPT1_PFS3, OPT1_PFS4);
		`CHK(dec, D1)
	endtask

	task automatic t_override;
		wr(ADDR_PFS2, 8'h00);
		@(negedge mclk);
		rd_chk(ADDR_PFS2, 8'h00);
		`CHK({fs, v12, v5, cv}, {8'h1F, 3'b110, 1'b1, 2'b01})
		wr(ADDR_PFS3, 8'h30);
		@(negedge mclk);
		rd_chk(ADDR_PFS3, 8'h30);
		`CHK({cv, ro, v1v2, batt, intr, ffs}, 8'hD5)
		wr(ADDR_PFS1, 8'hFF);
		@(negedge mclk);
		`CHK({volt_id, fs, fd, th}, {1'b1, 8'h10, 4'h4, 2'b10})
		wr(ADDR_PFS4, 8'h5C);
		@(negedge mclk);
		`CHK({gp, th, fd}, {2'b10, 2'b00, 4'h4})
	endtask

	task automatic t_setup;
		ce = 1'b0;
		wr(ADDR_GCFG1, 8'h20);
		ce = 1'b1;
		rd_chk(ADDR_GCFG1, GCFG1_RST);
		`CHK(mon, 1'b0)
		wr(ADDR_GCFG1, 8'h20);
		`CHK(mon, 1'b0)
		@(negedge mclk);
		`CHK(mon, 1'b1)
		rd_chk(ADDR_GCFG1, 8'h20);
		rd_chk(8'hFF, 8'h00);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		#(2000 * 40);
		fail_count++;
		give_verdict();
	end

	initial begin
		fail_count = 0;
		n_tests = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (6) @(negedge mclk);
		`CHK({dec, mon}, 38'h0)
		rst_n = 1'b1;
		@(negedge mclk);
		t_reset();
		t_presets();
		t_override();
		t_setup();
		give_verdict();
	end
endmodule

`default_nettype wire
